//--- toner_supply_consts.vh
`ifndef TONER_SUPPLY_CONSTS_VH
`define TONER_SUPPLY_CONSTS_VH
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_EMPTY_CFG 4'h2
`define ADDR_LIFE 4'h3
`define ADDR_COLOUR_BASE 4'h4
`define ADDR_EMPTY_COUNT 4'h8
`define CTRL_NEAR_LIFE_OFF 0
`define CTRL_EMPTY_RESTORE 1
`define CTRL_WIDTH 2
`define CTRL_RESET 2'h0
`define CART_STARTER 2'h0
`define CART_STANDARD 2'h1
`define CART_HIGH 2'h2
`define RUN_PER_PAGE_US 1000
`define CLK_MHZ 10
`define RUN_PER_PAGE_CYC (`RUN_PER_PAGE_US * `CLK_MHZ)
`define NEAR_STARTER_PAGES 1800
`define NEAR_STANDARD_PAGES 3600
`define NEAR_HIGH_PAGES 7200
`define LIFE_NEAR_SHEETS 18000
`define LIFE_LIMIT_SHEETS 30000
`define LIFE_END_SHEETS 30001
`define STOP_TIME_US 10
`define STOP_CYC (`STOP_TIME_US * `CLK_MHZ)
`define EMPTY_LEVEL_RESET 8'h20
`define EMPTY_TIME_RESET 16'h0100
`define EMPTY_TIMES_RESET 4'h3
`endif

//--- toner_supply_and_life_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "toner_supply_consts.vh"
module toner_supply_and_life_monitor (
	// clock and reset
	input wire clk_sys,
	input wire reset,
	// register port
	input wire [3:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [31:0] regRdData,
	// print engine
	input wire imagingUnitDriven,
	input wire frontDoorClosed,
	output reg printBlocked,
	output reg stabiliseRequest,
	// level sensors, order yellow magenta cyan black
	input wire [3:0] supplyNeeded,
	input wire [31:0] levelSensor,
	// cartridge boards
	input wire [3:0] cartridgePresent,
	input wire [3:0] cartridgeNew,
	input wire [7:0] cartridgeType,
	// imaging unit board
	input wire imagingUnitPlaced,
	input wire imagingUnitNew,
	// nonvolatile store of empty counts
	input wire [15:0] storedEmptyCount,
	output reg [15:0] emptyCountOut,
	// motors
	output reg yellowMagentaRun,
	output reg yellowMagentaCcw,
	output reg cyanBlackRun,
	output reg cyanBlackCcw,
	// indications
	output reg [3:0] nearEmpty,
	output reg [3:0] tonerEmpty,
	output reg nearLife,
	output reg lifeWarning,
	output reg lifeEnd
);
	localparam ST_IDLE = 2'd0;
	localparam ST_RUN = 2'd1;
	localparam ST_STOP = 2'd2;
	localparam DET_IDLE = 2'd0;
	localparam DET_CHECK = 2'd1;
	localparam DET_DONE = 2'd2;

	// configuration, motor and colour state
	reg [`CTRL_WIDTH-1:0] ctrl;
	reg [7:0] emptyLevel;
	reg [15:0] emptyTime;
	reg [3:0] emptyTimes;
	reg [1:0] motorState [0:1];
	reg [1:0] motorCcwSel;
	reg [1:0] lastServed;
	reg [7:0] stopCount [0:1];
	reg [31:0] runTime [0:3];
	reg [13:0] pageCyc [0:3];
	reg [15:0] lowTime [0:3];
	reg [3:0] doorSeen;
	reg doorPrev;
	reg [1:0] detState;
	reg [13:0] lifeCyc;
	reg [15:0] lifeSheets;
	reg [3:0] wantSupply;
	reg [3:0] newEvent;
	reg unitNewEvent;
	wire [1:0] motorRun;

	// supply request per colour and detection check decode
	always @* begin
		wantSupply = supplyNeeded & cartridgePresent & {4{imagingUnitDriven}};
		newEvent = (detState == DET_CHECK) ? (cartridgeNew & cartridgePresent) : 4'h0;
		unitNewEvent = (detState == DET_CHECK) && imagingUnitPlaced && imagingUnitNew;
	end

	// per motor direction control
	genvar m;
	generate
		for (m = 0; m < 2; m = m + 1) begin : motor
			wire cwReq = wantSupply[2*m];
			wire ccwReq = wantSupply[2*m+1];
			wire pickCcw = ccwReq && (!cwReq || !lastServed[m]);
			assign motorRun[m] = (motorState[m] == ST_RUN);
			always @(posedge clk_sys) begin
				if (reset) begin
					motorState[m] <= ST_IDLE;
					motorCcwSel[m] <= 1'b0;
					lastServed[m] <= 1'b0;
					stopCount[m] <= 8'h00;
				end else begin
					case (motorState[m])
						ST_IDLE: begin
							if (cwReq || ccwReq) begin
								motorCcwSel[m] <= pickCcw;
								lastServed[m] <= pickCcw;
								motorState[m] <= ST_RUN;
							end
						end
						ST_RUN: begin
							if (!wantSupply[2*m+motorCcwSel[m]] || (motorCcwSel[m] ? cwReq : ccwReq)) begin
								motorState[m] <= ST_STOP;
								stopCount[m] <= 8'h00;
							end
						end
						ST_STOP: begin
							if (stopCount[m] == (`STOP_CYC - 1)) begin
								motorState[m] <= ST_IDLE;
							end else begin
								stopCount[m] <= stopCount[m] + 8'h01;
							end
						end
						default: begin
							motorState[m] <= ST_IDLE;
						end
					endcase
				end
			end
		end
	endgenerate

	// registered motor drive
	always @(posedge clk_sys) begin
		if (reset) begin
			yellowMagentaRun <= 1'b0;
			yellowMagentaCcw <= 1'b0;
			cyanBlackRun <= 1'b0;
			cyanBlackCcw <= 1'b0;
		end else begin
			yellowMagentaRun <= motorRun[0] && wantSupply[motorCcwSel[0]];
			yellowMagentaCcw <= motorCcwSel[0];
			cyanBlackRun <= motorRun[1] && wantSupply[2+motorCcwSel[1]];
			cyanBlackCcw <= motorCcwSel[1];
		end
	end

	// per colour level, near-empty and empty detection
	genvar c;
	generate
		for (c = 0; c < 4; c = c + 1) begin : colour
			wire [1:0] cartKind = cartridgeType[2*c+1:2*c];
			wire running = motorRun[c/2] && (motorCcwSel[c/2] == (c % 2)) && wantSupply[c];
			wire [7:0] level = levelSensor[8*c+7:8*c];
			reg [31:0] nearPages;
			wire [31:0] pagesUsed = runTime[c];
			always @* begin
				case (cartKind)
					`CART_STANDARD: begin
						nearPages = `NEAR_STANDARD_PAGES;
					end
					`CART_HIGH: begin
						nearPages = `NEAR_HIGH_PAGES;
					end
					default: begin
						nearPages = `NEAR_STARTER_PAGES;
					end
				endcase
			end
			wire detectOn = nearEmpty[c] || (cartKind == `CART_STARTER);
			always @(posedge clk_sys) begin
				if (reset) begin
					runTime[c] <= 32'h00000000;
					pageCyc[c] <= 14'h0000;
					nearEmpty[c] <= 1'b0;
					tonerEmpty[c] <= 1'b0;
					lowTime[c] <= 16'h0000;
					emptyCountOut[4*c+3:4*c] <= 4'h0;
				end else if (newEvent[c]) begin
					runTime[c] <= 32'h00000000;
					pageCyc[c] <= 14'h0000;
					nearEmpty[c] <= 1'b0;
					tonerEmpty[c] <= 1'b0;
					lowTime[c] <= 16'h0000;
					emptyCountOut[4*c+3:4*c] <= 4'h0;
				end else begin
					if (regWrite && regAddr == `ADDR_CTRL && regWrData[`CTRL_EMPTY_RESTORE]) begin
						emptyCountOut[4*c+3:4*c] <= storedEmptyCount[4*c+3:4*c];
					end

					// run time accumulated in pages
					if (running) begin
						if (pageCyc[c] == (`RUN_PER_PAGE_CYC - 1)) begin
							pageCyc[c] <= 14'h0000;
							runTime[c] <= runTime[c] + 32'h00000001;
						end else begin
							pageCyc[c] <= pageCyc[c] + 14'h0001;
						end
					end
					if (pagesUsed >= nearPages) begin
						nearEmpty[c] <= 1'b1;
					end

					// empty event counting
					if (detectOn && !tonerEmpty[c]) begin
						if (level <= emptyLevel) begin
							if (lowTime[c] == emptyTime) begin
								lowTime[c] <= lowTime[c] + 16'h0001;
								if (emptyCountOut[4*c+3:4*c] + 4'h1 >= emptyTimes) begin
									tonerEmpty[c] <= 1'b1;
								end
								emptyCountOut[4*c+3:4*c] <= emptyCountOut[4*c+3:4*c] + 4'h1;
							end else if (lowTime[c] < emptyTime) begin
								lowTime[c] <= lowTime[c] + 16'h0001;
							end
						end else begin
							if (lowTime[c] <= emptyTime) begin
								emptyCountOut[4*c+3:4*c] <= 4'h0;
							end
							lowTime[c] <= 16'h0000;
						end
					end
				end
			end
		end
	endgenerate

	// imaging unit life and door detection
	always @(posedge clk_sys) begin
		if (reset) begin
			doorPrev <= 1'b0;
			detState <= DET_IDLE;
			stabiliseRequest <= 1'b0;
			lifeCyc <= 14'h0000;
			lifeSheets <= 16'h0000;
			nearLife <= 1'b0;
			lifeWarning <= 1'b0;
			lifeEnd <= 1'b0;
			printBlocked <= 1'b0;
		end else begin
			doorPrev <= frontDoorClosed;
			stabiliseRequest <= 1'b0;
			case (detState)
				DET_IDLE: begin
					if (frontDoorClosed && !doorPrev) begin
						detState <= DET_CHECK;
					end
				end
				DET_CHECK: begin
					detState <= DET_DONE;
					if (newEvent != 4'h0 || unitNewEvent) begin
						stabiliseRequest <= 1'b1;
					end
				end
				DET_DONE: begin
					detState <= DET_IDLE;
				end
				default: begin
					detState <= DET_IDLE;
				end
			endcase
			if (unitNewEvent) begin
				lifeCyc <= 14'h0000;
				lifeSheets <= 16'h0000;
				lifeEnd <= 1'b0;
				lifeWarning <= 1'b0;
				nearLife <= 1'b0;
				printBlocked <= 1'b0;
			end else begin

				// drive time accumulated in sheets
				if (imagingUnitDriven && lifeSheets != 16'hFFFF) begin
					if (lifeCyc == (`RUN_PER_PAGE_CYC - 1)) begin
						lifeCyc <= 14'h0000;
						lifeSheets <= lifeSheets + 16'h0001;
					end else begin
						lifeCyc <= lifeCyc + 14'h0001;
					end
				end

				// life thresholds
				nearLife <= (lifeSheets >= `LIFE_NEAR_SHEETS) && !ctrl[`CTRL_NEAR_LIFE_OFF];
				lifeWarning <= (lifeSheets >= `LIFE_LIMIT_SHEETS);
				lifeEnd <= (lifeSheets >= `LIFE_END_SHEETS);
				printBlocked <= (lifeSheets >= `LIFE_END_SHEETS);
			end
		end
	end

	// register port
	always @(posedge clk_sys) begin
		if (reset) begin
			ctrl <= `CTRL_RESET;
			emptyLevel <= `EMPTY_LEVEL_RESET;
			emptyTime <= `EMPTY_TIME_RESET;
			emptyTimes <= `EMPTY_TIMES_RESET;
			regRdData <= 32'h00000000;
		end else begin

			// configuration writes
			if (regWrite) begin
				case (regAddr)
					`ADDR_CTRL: begin
						ctrl <= {1'b0, regWrData[`CTRL_NEAR_LIFE_OFF]};
					end
					`ADDR_EMPTY_CFG: begin
						emptyLevel <= regWrData[7:0];
						emptyTime <= regWrData[23:8];
						emptyTimes <= regWrData[27:24];
					end
					default: ;
				endcase
			end

			// read data stands one cycle, zero otherwise
			regRdData <= 32'h00000000;
			if (regRead) begin
				case (regAddr)
					`ADDR_CTRL: begin
						regRdData <= {30'h00000000, ctrl};
					end
					`ADDR_STATUS: begin
						regRdData <= {16'h0000, emptyCountOut[15:12], tonerEmpty, nearEmpty,
							printBlocked, lifeEnd, lifeWarning, nearLife};
					end
					`ADDR_EMPTY_CFG: begin
						regRdData <= {4'h0, emptyTimes, emptyTime, emptyLevel};
					end
					`ADDR_LIFE: begin
						regRdData <= {16'h0000, lifeSheets};
					end
					`ADDR_COLOUR_BASE: begin
						regRdData <= runTime[0];
					end
					4'h5: begin
						regRdData <= runTime[1];
					end
					4'h6: begin
						regRdData <= runTime[2];
					end
					4'h7: begin
						regRdData <= runTime[3];
					end
					`ADDR_EMPTY_COUNT: begin
						regRdData <= {16'h0000, emptyCountOut};
					end
					default: begin
						regRdData <= 32'h00000000;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- toner_supply_checker.sv
`timescale 1ns/1ps
`default_nettype none
module toner_supply_checker (
	// watched ports
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic imagingUnitDriven,
	input wire logic frontDoorClosed,
	input wire logic printBlocked,
	input wire logic stabiliseRequest,
	input wire logic [3:0] cartridgePresent,
	input wire logic [3:0] cartridgeNew,
	input wire logic imagingUnitPlaced,
	input wire logic imagingUnitNew,
	input wire logic [15:0] emptyCountOut,
	input wire logic yellowMagentaRun,
	input wire logic yellowMagentaCcw,
	input wire logic cyanBlackRun,
	input wire logic cyanBlackCcw,
	input wire logic [3:0] nearEmpty,
	input wire logic [3:0] tonerEmpty,
	input wire logic lifeWarning,
	input wire logic lifeEnd
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire logic newCart = |(cartridgePresent & cartridgeNew);
	wire logic newUnit = imagingUnitPlaced & imagingUnitNew;
	a_supply_idle: assert property (!imagingUnitDriven [*3] |-> !yellowMagentaRun && !cyanBlackRun)
		else $error("motor runs while imaging unit is idle");
	a_ym_dir_hold: assert property (yellowMagentaRun && $past(yellowMagentaRun) |-> $stable(yellowMagentaCcw))
		else $error("yellow magenta motor reversed while running");
	a_cb_dir_hold: assert property (cyanBlackRun && $past(cyanBlackRun) |-> $stable(cyanBlackCcw))
		else $error("cyan black motor reversed while running");
	a_ym_stop_gap: assert property ($fell(yellowMagentaRun) |-> !yellowMagentaRun [*8])
		else $error("yellow magenta motor restarted without a full stop");
	a_cb_stop_gap: assert property ($fell(cyanBlackRun) |-> !cyanBlackRun [*8])
		else $error("cyan black motor restarted without a full stop");
	a_block_life: assert property (printBlocked == lifeEnd)
		else $error("print block differs from life end");
	a_stab_new: assert property ($rose(frontDoorClosed) && (newCart || newUnit) |-> ##[1:3] stabiliseRequest)
		else $error("no stabilisation request after new unit");
	a_stab_pulse: assert property (stabiliseRequest |=> !stabiliseRequest)
		else $error("stabilisation request longer than one cycle");
	a_cart_clear: assert property ($rose(frontDoorClosed) && cartridgePresent[0] && cartridgeNew[0]
		|-> ##2 !nearEmpty[0] && !tonerEmpty[0] && emptyCountOut[3:0] == 4'h0)
		else $error("new cartridge did not clear its flags");
	a_unit_clear: assert property ($rose(frontDoorClosed) && newUnit |-> ##2 !lifeEnd && !lifeWarning)
		else $error("new imaging unit did not clear life state");
	c_magenta: cover property (yellowMagentaRun && yellowMagentaCcw);
	c_cyan: cover property (cyanBlackRun && !cyanBlackCcw);
	c_empty: cover property (tonerEmpty[0]);
endmodule
`default_nettype wire

//--- supply_partner.sv
`timescale 1ns/1ps
`default_nettype none
module supply_partner (
	// clock and clear
	input wire logic clk_sys,
	input wire logic clr,
	// sensor demand and motors
	input wire logic [3:0] need,
	input wire logic ymRun,
	input wire logic ymCcw,
	input wire logic cbRun,
	input wire logic cbCcw,
	// to design and bench
	output logic [3:0] supplyNeeded,
	output logic [3:0] served
);
	assign supplyNeeded = need;
	// colour turned by each motor direction
	always @(posedge clk_sys) begin
		if (clr)
			served <= 4'h0;
		else
			served <= served | {cbRun & cbCcw, cbRun & ~cbCcw, ymRun & ymCcw, ymRun & ~ymCcw};
	end
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_sys = 1'h0, reset = 1'h1, regWrite = 1'h0, regRead = 1'h0, clr = 1'h0;
	logic imagingUnitDriven = 1'h0, frontDoorClosed = 1'h0, imagingUnitPlaced = 1'h1, imagingUnitNew = 1'h0;
	logic [3:0] regAddr = 4'h0, need = 4'h0, cartridgePresent = 4'hF, cartridgeNew = 4'h0;
	logic [31:0] regWrData = 32'h0, levelSensor = 32'hFFFFFFFF, v;
	logic [7:0] cartridgeType = 8'h55;
	logic [15:0] storedEmptyCount = 16'h0;
	wire [31:0] regRdData;
	wire [15:0] emptyCountOut;
	wire [3:0] supplyNeeded, nearEmpty, tonerEmpty, served;
	wire printBlocked, stabiliseRequest, yellowMagentaRun, yellowMagentaCcw, cyanBlackRun, cyanBlackCcw;
	wire nearLife, lifeWarning, lifeEnd;
	int errors = 0, checked = 0, i, n;
	toner_supply_and_life_monitor toner_supply_and_life_monitor_inst (.clk_sys, .reset, .regAddr, .regWrData,
		.regWrite, .regRead, .regRdData, .imagingUnitDriven, .frontDoorClosed, .printBlocked, .stabiliseRequest,
		.supplyNeeded, .levelSensor, .cartridgePresent, .cartridgeNew, .cartridgeType, .imagingUnitPlaced,
		.imagingUnitNew, .storedEmptyCount, .emptyCountOut, .yellowMagentaRun, .yellowMagentaCcw, .cyanBlackRun,
		.cyanBlackCcw, .nearEmpty, .tonerEmpty, .nearLife, .lifeWarning, .lifeEnd);
	supply_partner supply_partner_inst (.clk_sys, .clr, .need, .ymRun(yellowMagentaRun), .ymCcw(yellowMagentaCcw),
		.cbRun(cyanBlackRun), .cbCcw(cyanBlackCcw), .supplyNeeded, .served);
	initial forever #50 clk_sys = ~clk_sys;
	function automatic logic [3:0] expServe(input logic [3:0] nd, pr, input logic drv);
		return nd & pr & {4{drv}};
	endfunction
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWrite <= 1'h1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrite <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'h0;
		#1 cmp(regRdData, e);
	endtask
	task automatic await(input bit sel);
		for (n = 0; n < 200; n++) begin
			@(posedge clk_sys);
			#1;
			if ((sel ? tonerEmpty[0] : stabiliseRequest) === 1'h1)
				return;
		end
		errors++;
		finish_test();
	endtask
	initial begin
		void'($urandom(32'h4E55));
		repeat (20) @(posedge clk_sys);
		reset <= 1'h0;
		rd(4'h0, 32'h0);
		rd(4'h2, 32'h03010020);
		rd(4'hF, 32'h0);
		cmp({nearLife, lifeWarning, lifeEnd, printBlocked}, 4'h0);
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			need <= (i == 0) ? 4'hF : 4'($urandom);
			cartridgePresent <= (i < 2) ? 4'hF : 4'($urandom);
			imagingUnitDriven <= (i != 1);
			repeat (8) @(posedge clk_sys);
			clr <= 1'h1;
			@(posedge clk_sys);
			clr <= 1'h0;
			repeat (600) @(posedge clk_sys);
			cmp(served, expServe(need, cartridgePresent, imagingUnitDriven));
		end
		need <= 4'h0;
		cartridgePresent <= 4'hF;
		$display("test supply done");
		v = $urandom;
		storedEmptyCount <= v[15:0];
		wr(4'h0, 32'h3);
		rd(4'h8, {16'h0, v[15:0]});
		rd(4'h0, 32'h1);
		$display("test restore done");
		storedEmptyCount <= 16'h0;
		wr(4'h0, 32'h2);
		wr(4'h2, 32'h02000420);
		cartridgeType <= 8'h54;
		levelSensor <= 32'hFFFF1010;
		repeat (2) begin
			repeat (8) @(posedge clk_sys);
			levelSensor <= 32'hFFFF10FF;
			@(posedge clk_sys);
			levelSensor <= 32'hFFFF1010;
		end
		await(1'h1);
		cmp({tonerEmpty, emptyCountOut[7:4]}, 8'h10);
		$display("test empty done");
		@(posedge clk_sys);
		cartridgeNew <= 4'h1;
		imagingUnitNew <= 1'h1;
		@(posedge clk_sys);
		frontDoorClosed <= 1'h1;
		await(1'h0);
		cmp({nearEmpty[0], tonerEmpty[0], emptyCountOut[3:0], lifeEnd}, 7'h0);
		$display("test door done");
		finish_test();
	end
endmodule
bind toner_supply_and_life_monitor toner_supply_checker toner_supply_checker_inst (.clk_sys, .reset,
	.imagingUnitDriven, .frontDoorClosed, .printBlocked, .stabiliseRequest, .cartridgePresent, .cartridgeNew,
	.imagingUnitPlaced, .imagingUnitNew, .emptyCountOut, .yellowMagentaRun, .yellowMagentaCcw, .cyanBlackRun,
	.cyanBlackCcw, .nearEmpty, .tonerEmpty, .lifeWarning, .lifeEnd);
`default_nettype wire
